// File: common/mfpt_pkg.sv
// package: offsets, field positions, reset values and carrier types of the monitor flag bank
package mfpt_pkg;
  localparam logic [7:0] MFPT_OFS_FAST_A = 8'h72;
  localparam logic [7:0] MFPT_OFS_FAST_B = 8'h73;
  localparam logic [7:0] MFPT_OFS_WARN_P = 8'h74;
  localparam logic [7:0] MFPT_OFS_WARN_M = 8'h75;
  localparam logic [7:0] MFPT_OFS_RSVD_LO = 8'h76;
  localparam logic [7:0] MFPT_OFS_RSVD_HI = 8'h7A;
  localparam logic [7:0] MFPT_OFS_PW_LO = 8'h7B;
  localparam logic [7:0] MFPT_OFS_PW_HI = 8'h7E;
  localparam logic [7:0] MFPT_OFS_TBL = 8'h7F;
  localparam logic [7:0] MFPT_RST_FAST = 8'h00;
  localparam logic [7:0] MFPT_RST_WARN_P = 8'h10;
  localparam logic [7:0] MFPT_RST_WARN_M = 8'h00;
  localparam logic [31:0] MFPT_RST_PW = 32'hFFFFFFFF;
  localparam logic [7:0] MFPT_READ_ZERO = 8'h00;
  localparam int MFPT_BIT_TX_POWER_LOW_FAST_ALARM = 0;
  localparam int MFPT_BIT_TX_POWER_HIGH_FAST_ALARM = 1;
  localparam int MFPT_BIT_HBIAS = 3;
  localparam int MFPT_BIT_BMAX = 3;
  localparam int MFPT_BIT_RX_LO = 6;
  localparam int MFPT_BIT_RX_HI = 7;
  localparam int MFPT_BIT_SUP_LO = 4;
  localparam int MFPT_BIT_TEMPERATURE_HIGH_FLAG = 7;
  localparam int MFPT_BIT_TEMPERATURE_LOW_FLAG = 6;
  localparam int MFPT_BIT_SUP_HI = 5;
  localparam int MFPT_BIT_MONITOR_INPUT_1_HI = 3;
  localparam int MFPT_BIT_MONITOR_INPUT_1_LO = 2;
  localparam int MFPT_BIT_MONITOR_INPUT_2_HI = 1;
  localparam int MFPT_BIT_MONITOR_INPUT_2_LO = 0;
  localparam int MFPT_BIT_MONITOR_INPUT_3_HI = 7;
  localparam int MFPT_BIT_MONITOR_INPUT_3_LO = 6;
  localparam int MFPT_BIT_MONITOR_INPUT_4_HI = 5;
  localparam int MFPT_BIT_MONITOR_INPUT_4_LO = 4;
  localparam logic [7:0] MFPT_MASK_RX = 8'hC0;
  localparam logic [7:0] MFPT_MASK_WARN_RSVD = 8'h0F;
  localparam int MFPT_PW_BYTES = 4;
  localparam logic [1:0] MFPT_PW_IDX_LAST = 2'h3;

  typedef enum logic [1:0] {
    MFPT_ACC_USER,
    MFPT_ACC_LOWER,
    MFPT_ACC_UPPER
  } mfpt_access_t;

  // one fast-comparison sample set, valid only with its strobe
  typedef struct packed {
    logic strobe;
    logic bias_high;
    logic txp_high;
    logic txp_low;
    logic rx_high;
    logic rx_low;
  } mfpt_fast_t;

  // one completed slow measurement with its comparison results
  typedef struct packed {
    logic done;
    logic high;
    logic low;
  } mfpt_meas_t;

  // host side byte access to the lower memory
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mfpt_bus_t;
endpackage

// File: rtl/mfpt_pw_regs.sv
// password entry bytes: write-only storage with a registered comparison
`timescale 1ns/1ps
`default_nettype none
module mfpt_pw_regs
  import mfpt_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic wr_in,
  input wire logic [1:0] idx_in,
  input wire logic [7:0] wdata_in,
  input wire logic [WIDTH-1:0] lower_pw_in,
  input wire logic [WIDTH-1:0] upper_pw_in,
  output mfpt_access_t level_out
);
  logic [WIDTH-1:0] entry_q;
  logic cmp_q;

  // =====================================================================
  // byte storage
  // preset ones
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      entry_q <= MFPT_RST_PW;
    end else if (clk_en_in && wr_in) begin
      // byte at the lowest offset holds the most significant bits
      entry_q[WIDTH-1-8*idx_in -: 8] <= wdata_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cmp_q <= 1'b0;
    end else if (clk_en_in) begin
      cmp_q <= wr_in;
    end
  end

  // =====================================================================
  // level grant, recomputed one cycle after any entry byte write
  // highest match wins
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      level_out <= MFPT_ACC_USER;
    end else if (clk_en_in && cmp_q) begin
      if (entry_q == upper_pw_in) begin
        level_out <= MFPT_ACC_UPPER;
      end else if (entry_q == lower_pw_in) begin
        level_out <= MFPT_ACC_LOWER;
      end else begin
        level_out <= MFPT_ACC_USER;
      end
    end
  end

  a_level_follows: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (clk_en_in && cmp_q && entry_q == upper_pw_in) |=> level_out == MFPT_ACC_UPPER)
    else $error("upper match not granted");
  a_lower_grant: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (clk_en_in && cmp_q && entry_q != upper_pw_in && entry_q == lower_pw_in)
    |=> level_out == MFPT_ACC_LOWER)
    else $error("lower match not granted");
endmodule
`default_nettype wire

// File: rtl/mfpt_flag_bank.sv
// lower-memory flag, password and table select register bank
`timescale 1ns/1ps
`default_nettype none
module mfpt_flag_bank
  import mfpt_pkg::*;
#(
  parameter int PW_WIDTH = 32,
  parameter int BIAS_WIDTH = 10
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire mfpt_bus_t bus_in,
  output logic [7:0] rdata_out,
  input wire mfpt_fast_t fast_in,
  input wire logic tx_disable_event_in,
  input wire logic [BIAS_WIDTH-1:0] bias_request_in,
  input wire logic [BIAS_WIDTH-1:0] bias_ceiling_limit_in,
  input wire mfpt_meas_t temp_meas_in,
  input wire mfpt_meas_t supply_meas_in,
  input wire mfpt_meas_t monitor_input_1_meas_in,
  input wire mfpt_meas_t monitor_input_2_meas_in,
  input wire mfpt_meas_t monitor_input_3_meas_in,
  input wire mfpt_meas_t monitor_input_4_meas_in,
  input wire logic below_poweron_trip_in,
  input wire logic [7:0] alarm_en_primary_in,
  input wire logic [7:0] alarm_en_monitors_in,
  input wire logic [7:0] alarm_primary_in,
  input wire logic [7:0] alarm_monitors_in,
  input wire logic [7:0] fast_en_b_in,
  input wire logic [7:0] warn_en_primary_in,
  input wire logic [7:0] warn_en_monitors_in,
  input wire logic [PW_WIDTH-1:0] lower_password_in,
  input wire logic [PW_WIDTH-1:0] upper_password_in,
  input wire logic [7:0] table_select_poweron_in,
  output logic [7:0] table_select_out,
  output mfpt_access_t access_level_out,
  output logic tx_fault_interrupt_out
);
  logic [7:0] fast_a_q;
  logic [7:0] fast_b_q;
  logic [7:0] warn_p_q;
  logic [7:0] warn_m_q;
  logic load_tbl_q;
  logic pw_hit;
  logic tbl_hit;
  logic rsvd_hit;
  logic [1:0] pw_idx;
  logic tx_off;
  logic [7:0] rd_d;
  logic fault_d;

  assign tx_off = tx_disable_event_in;
  assign pw_hit = bus_in.addr >= MFPT_OFS_PW_LO && bus_in.addr <= MFPT_OFS_PW_HI;
  assign tbl_hit = bus_in.addr == MFPT_OFS_TBL;
  assign rsvd_hit = bus_in.addr >= MFPT_OFS_RSVD_LO && bus_in.addr <= MFPT_OFS_RSVD_HI;
  assign pw_idx = 2'(bus_in.addr - MFPT_OFS_PW_LO);

  // =====================================================================
  // fast comparison flags; disable event outranks a fresh sample, except for the receive flags, which follow the strobe
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      fast_a_q <= MFPT_RST_FAST;
    end else if (clk_en_in) begin
      if (tx_off) begin
        fast_a_q[MFPT_BIT_HBIAS] <= 1'b0;
        fast_a_q[MFPT_BIT_TX_POWER_HIGH_FAST_ALARM] <= 1'b0;
        fast_a_q[MFPT_BIT_TX_POWER_LOW_FAST_ALARM] <= 1'b0;
      end else if (fast_in.strobe) begin
        fast_a_q[MFPT_BIT_HBIAS] <= fast_in.bias_high;
        fast_a_q[MFPT_BIT_TX_POWER_HIGH_FAST_ALARM] <= fast_in.txp_high;
        fast_a_q[MFPT_BIT_TX_POWER_LOW_FAST_ALARM] <= fast_in.txp_low;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      fast_b_q <= MFPT_RST_FAST;
    end else if (clk_en_in) begin
      if (fast_in.strobe) begin
        fast_b_q[MFPT_BIT_RX_HI] <= fast_in.rx_high;
        fast_b_q[MFPT_BIT_RX_LO] <= fast_in.rx_low;
      end
      fast_b_q[MFPT_BIT_BMAX] <= !tx_off && (bias_request_in > bias_ceiling_limit_in);
    end
  end

  // =====================================================================
  // measurement warnings; source supplies strict compare results
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      warn_p_q <= MFPT_RST_WARN_P;
    end else if (clk_en_in) begin
      if (temp_meas_in.done) begin
        warn_p_q[MFPT_BIT_TEMPERATURE_HIGH_FLAG] <= temp_meas_in.high;
        warn_p_q[MFPT_BIT_TEMPERATURE_LOW_FLAG] <= temp_meas_in.low;
      end
      if (supply_meas_in.done) begin
        warn_p_q[MFPT_BIT_SUP_HI] <= supply_meas_in.high;
      end
      if (below_poweron_trip_in) begin
        warn_p_q[MFPT_BIT_SUP_LO] <= 1'b1;
      end else if (supply_meas_in.done) begin
        warn_p_q[MFPT_BIT_SUP_LO] <= supply_meas_in.low;
      end
      if (monitor_input_1_meas_in.done) begin
        warn_p_q[MFPT_BIT_MONITOR_INPUT_1_HI] <= monitor_input_1_meas_in.high;
        warn_p_q[MFPT_BIT_MONITOR_INPUT_1_LO] <= monitor_input_1_meas_in.low;
      end
      if (monitor_input_2_meas_in.done) begin
        warn_p_q[MFPT_BIT_MONITOR_INPUT_2_HI] <= monitor_input_2_meas_in.high;
        warn_p_q[MFPT_BIT_MONITOR_INPUT_2_LO] <= monitor_input_2_meas_in.low;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      warn_m_q <= MFPT_RST_WARN_M;
    end else if (clk_en_in) begin
      // monitors 3 and 4, low nibble stays zero
      if (monitor_input_3_meas_in.done) begin
        warn_m_q[MFPT_BIT_MONITOR_INPUT_3_HI] <= monitor_input_3_meas_in.high;
        warn_m_q[MFPT_BIT_MONITOR_INPUT_3_LO] <= monitor_input_3_meas_in.low;
      end
      if (monitor_input_4_meas_in.done) begin
        warn_m_q[MFPT_BIT_MONITOR_INPUT_4_HI] <= monitor_input_4_meas_in.high;
        warn_m_q[MFPT_BIT_MONITOR_INPUT_4_LO] <= monitor_input_4_meas_in.low;
      end
    end
  end

  // =====================================================================
  // table select; power-on value is taken on the first enabled edge after reset
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      load_tbl_q <= 1'b1;
    end else if (clk_en_in) begin
      load_tbl_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      table_select_out <= MFPT_READ_ZERO;
    end else if (clk_en_in) begin
      if (load_tbl_q) begin
        table_select_out <= table_select_poweron_in;
      end else if (bus_in.wr && tbl_hit) begin
        table_select_out <= bus_in.wdata;
      end
    end
  end

  mfpt_pw_regs #(
    .WIDTH(PW_WIDTH)
  ) u_pw (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .wr_in(bus_in.wr && pw_hit),
    .idx_in(pw_idx),
    .wdata_in(bus_in.wdata),
    .lower_pw_in(lower_password_in),
    .upper_pw_in(upper_password_in),
    .level_out(access_level_out)
  );

  // =====================================================================
  // read mux; data valid the cycle after the read strobe
  always_comb begin
    rd_d = MFPT_READ_ZERO;
    unique case (bus_in.addr)
      MFPT_OFS_FAST_A: rd_d = fast_a_q;
      MFPT_OFS_FAST_B: rd_d = fast_b_q;
      MFPT_OFS_WARN_P: rd_d = warn_p_q;
      MFPT_OFS_WARN_M: rd_d = warn_m_q;
      MFPT_OFS_TBL: rd_d = table_select_out;
      default: rd_d = MFPT_READ_ZERO;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rdata_out <= MFPT_READ_ZERO;
    end else if (clk_en_in && bus_in.rd) begin
      rdata_out <= rd_d;
    end
  end

  // =====================================================================
  // fault interrupt; fast flags without enable bypass masking
  // OR of gated flags and the ungated fast flags
  always_comb begin
    fault_d = |(alarm_primary_in & alarm_en_primary_in)
      | |(alarm_monitors_in & alarm_en_monitors_in)
      | |(warn_p_q & warn_en_primary_in)
      | |(warn_m_q & warn_en_monitors_in)
      | |(fast_b_q & fast_en_b_in & MFPT_MASK_RX)
      | fast_a_q[MFPT_BIT_HBIAS] | fast_a_q[MFPT_BIT_TX_POWER_HIGH_FAST_ALARM] | fast_a_q[MFPT_BIT_TX_POWER_LOW_FAST_ALARM]
      | fast_b_q[MFPT_BIT_BMAX];
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tx_fault_interrupt_out <= 1'b0;
    end else if (clk_en_in) begin
      tx_fault_interrupt_out <= fault_d;
    end
  end

  // =====================================================================
  // checks
  sequence s_disable_on;
    clk_en_in && tx_off;
  endsequence

  a_disable_clears: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_disable_on |=> fast_a_q[MFPT_BIT_HBIAS] == 1'b0)
    else $error("bias flag survived disable");
  a_txp_high: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (clk_en_in && !tx_off && fast_in.strobe) |=> fast_a_q[MFPT_BIT_TX_POWER_HIGH_FAST_ALARM] == $past(fast_in.txp_high))
    else $error("power high flag wrong");
  a_txp_low: assert property (@(posedge core_clk_in) disable iff (reset_in)
    s_disable_on |=> !fast_a_q[MFPT_BIT_TX_POWER_LOW_FAST_ALARM])
    else $error("power low flag survived disable");
  a_rx_kept: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (clk_en_in && tx_off && !fast_in.strobe) |=> $stable(fast_b_q & MFPT_MASK_RX))
    else $error("receive flags changed on disable");
  a_ceiling_flag: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (clk_en_in && !tx_off) |=> fast_b_q[MFPT_BIT_BMAX] == ($past(bias_request_in) > $past(bias_ceiling_limit_in)))
    else $error("ceiling flag wrong");
  a_supply_forced: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (clk_en_in && below_poweron_trip_in) |=> warn_p_q[MFPT_BIT_SUP_LO])
    else $error("supply low not forced");
  a_rsvd_nibble: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (warn_m_q & MFPT_MASK_WARN_RSVD) == MFPT_READ_ZERO)
    else $error("reserved warning bits set");
  a_pw_reads_zero: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (clk_en_in && bus_in.rd && (pw_hit || rsvd_hit)) |=> rdata_out == MFPT_READ_ZERO)
    else $error("password or reserved read nonzero");
  a_table_write: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (clk_en_in && !load_tbl_q && bus_in.wr && tbl_hit) |=> table_select_out == $past(bus_in.wdata))
    else $error("table select not written");
  a_fast_int: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (clk_en_in && fast_a_q[MFPT_BIT_TX_POWER_HIGH_FAST_ALARM]) |=> tx_fault_interrupt_out)
    else $error("ungated flag missed interrupt");
endmodule
`default_nettype wire

// File: testbench/mfpt_host_model.sv
// host controller model: byte writes and reads on the lower memory bus
`timescale 1ns/1ps
`default_nettype none
module mfpt_host_model
  import mfpt_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic [7:0] rdata_in,
  output mfpt_bus_t bus_out
);
  // ==========================================================
  // bus driving
  initial begin
    bus_out = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
  end

  // idle bus shows the inverse of the last request, so a stale copy never passes
  task automatic release_bus();
    bus_out <= '{wr: 1'b0, rd: 1'b0, addr: ~bus_out.addr, wdata: ~bus_out.wdata};
  endtask

  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk_in);
    bus_out <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge core_clk_in);
    release_bus();
    #1;
  endtask

  // read data is registered, so it is taken just after the edge that accepts the strobe
  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
    @(posedge core_clk_in);
    bus_out <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge core_clk_in);
    release_bus();
    #1;
    data = rdata_in;
  endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the monitor flag, password and table select bank
`timescale 1ns/1ps
`default_nettype none
module tb
  import mfpt_pkg::*;
;
  // ==========================================================
  // stimulus and observed signals
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_en = 1'b1;
  mfpt_bus_t bus;
  logic [7:0] rdata;
  mfpt_fast_t fast = '0;
  logic tx_dis = 1'b0;
  logic [9:0] bias_req = 10'h100;
  logic [9:0] bias_lim = 10'h200;
  mfpt_meas_t meas [6] = '{default: '0};
  logic trip = 1'b0;
  logic [7:0] al_en_p = 8'h00;
  logic [7:0] al_en_m = 8'h00;
  logic [7:0] al_p = 8'h00;
  logic [7:0] fen_b = 8'h00;
  logic [7:0] wen_p = 8'h00;
  logic [7:0] wen_m = 8'h00;
  logic [31:0] pw_lo = 32'hFFFFFF00;
  logic [31:0] pw_hi = 32'h55667788;
  logic [7:0] tsel_pon = 8'h03;
  logic [7:0] tsel;
  mfpt_access_t acc;
  logic irq;
  int err_count = 0;
  int compares = 0;

  always #50 core_clk_in = ~core_clk_in;

  mfpt_host_model i_mfpt_host_model (
    .core_clk_in(core_clk_in),
    .rdata_in(rdata),
    .bus_out(bus)
  );

  mfpt_flag_bank i_mfpt_flag_bank (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en),
    .bus_in(bus),
    .rdata_out(rdata),
    .fast_in(fast),
    .tx_disable_event_in(tx_dis),
    .bias_request_in(bias_req),
    .bias_ceiling_limit_in(bias_lim),
    .temp_meas_in(meas[0]),
    .supply_meas_in(meas[1]),
    .monitor_input_1_meas_in(meas[2]),
    .monitor_input_2_meas_in(meas[3]),
    .monitor_input_3_meas_in(meas[4]),
    .monitor_input_4_meas_in(meas[5]),
    .below_poweron_trip_in(trip),
    .alarm_en_primary_in(al_en_p),
    .alarm_en_monitors_in(al_en_m),
    .alarm_primary_in(al_p),
    .alarm_monitors_in(8'hFF),
    .fast_en_b_in(fen_b),
    .warn_en_primary_in(wen_p),
    .warn_en_monitors_in(wen_m),
    .lower_password_in(pw_lo),
    .upper_password_in(pw_hi),
    .table_select_poweron_in(tsel_pon),
    .table_select_out(tsel),
    .access_level_out(acc),
    .tx_fault_interrupt_out(irq)
  );

  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    i_mfpt_host_model.read_byte(addr, d);
    chk(d, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_mfpt_host_model.write_byte(a, d);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  // bit order: bias, txp high, txp low, rx high, rx low
  task automatic fast_sample(input logic [4:0] f);
    @(posedge core_clk_in);
    fast <= {1'b1, f};
    @(posedge core_clk_in);
    fast.strobe <= 1'b0;
    cyc(1);
  endtask

  // index: temp, supply, monitor_input_1, monitor_input_2, monitor_input_3, monitor_input_4
  task automatic measure(input logic [5:0] hi, input logic [5:0] lo);
    @(posedge core_clk_in);
    for (int i = 0; i < 6; i++) meas[i] <= '{done: 1'b1, high: hi[i], low: lo[i]};
    @(posedge core_clk_in);
    for (int i = 0; i < 6; i++) meas[i].done <= 1'b0;
    cyc(1);
  endtask

  task automatic wrap_up();
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #2000000;
    err_count++;
    wrap_up();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (4) @(posedge core_clk_in);
    reset_in <= 1'b0;
    cyc(3);
    chk(tsel, 8'h03);
    rd_chk(8'h72, 8'h00);
    rd_chk(8'h73, 8'h00);
    rd_chk(8'h74, 8'h10);
    rd_chk(8'h75, 8'h00);
    rd_chk(8'h7F, 8'h03);
    for (int a = 8'h76; a <= 8'h7E; a++) rd_chk(8'(a), 8'h00);
    wr(8'h76, 8'hAA);
    wr(8'h72, 8'hFF);
    rd_chk(8'h76, 8'h00);
    rd_chk(8'h72, 8'h00);
    wr(8'h7F, 8'h05);
    chk(tsel, 8'h05);
    rd_chk(8'h7F, 8'h05);
    // clock enable low: a write must not land
    @(posedge core_clk_in);
    clk_en <= 1'b0;
    wr(8'h7F, 8'h0A);
    chk(tsel, 8'h05);
    @(posedge core_clk_in);
    clk_en <= 1'b1;
    // ceiling: equality must stay clear
    @(posedge core_clk_in);
    bias_req <= 10'h200;
    cyc(2);
    rd_chk(8'h73, 8'h00);
    @(posedge core_clk_in);
    bias_req <= 10'h201;
    cyc(2);
    rd_chk(8'h73, 8'h08);
    @(posedge core_clk_in);
    tx_dis <= 1'b1;
    cyc(2);
    rd_chk(8'h73, 8'h00);
    @(posedge core_clk_in);
    tx_dis <= 1'b0;
    bias_req <= 10'h100;
    fast_sample(5'b01000);
    rd_chk(8'h72, 8'h02);
    chk({7'h0, irq}, 8'h01);
    fast_sample(5'b10111);
    rd_chk(8'h72, 8'h09);
    rd_chk(8'h73, 8'hC0);
    @(posedge core_clk_in);
    tx_dis <= 1'b1;
    @(posedge core_clk_in);
    tx_dis <= 1'b0;
    rd_chk(8'h72, 8'h00);
    rd_chk(8'h73, 8'hC0);
    chk({7'h0, irq}, 8'h00);
    @(posedge core_clk_in);
    fen_b <= 8'h80;
    cyc(3);
    chk({7'h0, irq}, 8'h01);
    fast_sample(5'b00000);
    rd_chk(8'h73, 8'h00);
    @(posedge core_clk_in);
    fen_b <= 8'h00;
    measure(6'b010111, 6'b101000);
    rd_chk(8'h74, 8'hA9);
    rd_chk(8'h75, 8'h90);
    chk({7'h0, irq}, 8'h00);
    @(posedge core_clk_in);
    wen_p <= 8'h80;
    cyc(3);
    chk({7'h0, irq}, 8'h01);
    @(posedge core_clk_in);
    wen_p <= 8'h00;
    wen_m <= 8'h10;
    cyc(3);
    chk({7'h0, irq}, 8'h01);
    @(posedge core_clk_in);
    wen_m <= 8'h00;
    al_en_m <= 8'h01;
    cyc(3);
    chk({7'h0, irq}, 8'h01);
    @(posedge core_clk_in);
    al_en_m <= 8'h00;
    al_p <= 8'h04;
    al_en_p <= 8'h04;
    cyc(3);
    chk({7'h0, irq}, 8'h01);
    @(posedge core_clk_in);
    al_en_p <= 8'h00;
    measure(6'b101000, 6'b010111);
    rd_chk(8'h74, 8'h56);
    rd_chk(8'h75, 8'h60);
    chk({7'h0, irq}, 8'h00);
    measure(6'b000000, 6'b000000);
    rd_chk(8'h74, 8'h00);
    rd_chk(8'h75, 8'h00);
    // supply low is sticky after the trip until a good measurement
    @(posedge core_clk_in);
    trip <= 1'b1;
    cyc(2);
    rd_chk(8'h74, 8'h10);
    measure(6'b000000, 6'b000000);
    rd_chk(8'h74, 8'h10);
    @(posedge core_clk_in);
    trip <= 1'b0;
    rd_chk(8'h74, 8'h10);
    measure(6'b000000, 6'b000000);
    rd_chk(8'h74, 8'h00);
    chk({6'h0, acc}, {6'h0, MFPT_ACC_USER});
    wr(8'h7E, 8'h00);
    cyc(2);
    chk({6'h0, acc}, {6'h0, MFPT_ACC_LOWER});
    wr(8'h7B, 8'h55);
    wr(8'h7C, 8'h66);
    wr(8'h7D, 8'h77);
    wr(8'h7E, 8'h88);
    cyc(2);
    chk({6'h0, acc}, {6'h0, MFPT_ACC_UPPER});
    rd_chk(8'h7B, 8'h00);
    rd_chk(8'h7E, 8'h00);
    wr(8'h7D, 8'h00);
    cyc(2);
    chk({6'h0, acc}, {6'h0, MFPT_ACC_USER});
    // second reset in mid-run: power-on load and entry preset must repeat
    @(posedge core_clk_in);
    tsel_pon <= 8'h09;
    reset_in <= 1'b1;
    cyc(2);
    @(posedge core_clk_in);
    reset_in <= 1'b0;
    cyc(2);
    chk(tsel, 8'h09);
    rd_chk(8'h74, 8'h10);
    wr(8'h7E, 8'h00);
    cyc(2);
    chk({6'h0, acc}, {6'h0, MFPT_ACC_LOWER});
    wrap_up();
  end
endmodule
`default_nettype wire
